// ===== src/ecr_pkg.sv
// Constants, register map and types shared by the timeslot redirect block.
// Assumes a 32-bit classic Wishbone slave port and byte-wide stream channels.
package ecr_pkg;

  // ---------------------------------------------------------------------
  // Stream geometry
  // ---------------------------------------------------------------------
  localparam int CH_W       = 5;
  localparam int BYTE_W     = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_W     = CH_W + 3 * BYTE_W;
  localparam int MEM_AW     = CH_W + 1;

  localparam logic [CH_W-1:0] SLOT15 = 5'h0f;
  localparam logic [CH_W-1:0] SLOT16 = 5'h10;
  localparam logic [CH_W-1:0] SLOT31 = 5'h1f;
  localparam logic [CH_W-1:0] SLOT0  = 5'h00;

  localparam logic [BYTE_W-1:0] IDLE_BYTE = 8'hff;

  // ---------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------
  localparam logic [3:0] OFS_REDIRECT_CTRL = 4'h0;
  localparam logic [3:0] OFS_CHANNEL_MAP   = 4'h4;
  localparam logic [3:0] OFS_SIG_CFG       = 4'h8;
  localparam logic [3:0] OFS_STATUS        = 4'hc;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int CTRL_EN15_BIT = 0;
  localparam int CTRL_EN16_BIT = 1;
  localparam int CTRL_EN31_BIT = 2;
  localparam int MAP15_LSB     = 0;
  localparam int MAP16_LSB     = 5;
  localparam int MAP31_LSB     = 10;
  localparam int SIGCFG_CCS_BIT = 0;
  localparam int STAT_CH_LSB   = 0;
  localparam int STAT_BANK_BIT = 5;
  localparam int STAT_SYNC_BIT = 6;
  localparam int STAT_OUTV_BIT = 7;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [2:0]      CTRL_RESET  = 3'h0;
  localparam logic [CH_W-1:0] MAP31_RESET = 5'h1f;
  localparam logic [CH_W-1:0] MAP16_RESET = 5'h10;
  localparam logic [CH_W-1:0] MAP15_RESET = 5'h0f;
  localparam logic            CCS_RESET   = 1'b0;

  // ---------------------------------------------------------------------
  // Frame tracking states
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    ECR_SYNC  = 2'b00,
    ECR_FRAME = 2'b01
  } ecr_state_type;

endpackage

// ===== src/ecr_fifo.sv
// Shift-register FIFO with valid/ready on both sides; head entry is a flop.
// Assumes one clock and a synchronous active-high reset.
module ecr_fifo #(
  parameter int W     = 29,
  parameter int DEPTH = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  output logic              room2_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [CW-1:0] wr_idx;
  logic [W-1:0]  q_r   [DEPTH];
  logic [W-1:0]  q_nxt [DEPTH];
  logic          push;
  logic          pop;

  // ---------------------------------------------------------------------
  // Occupancy
  // ---------------------------------------------------------------------
  always_comb begin
    pop     = out_valid_o & out_ready_i;
    push    = in_valid_i & in_ready_o;
    wr_idx  = cnt_r - CW'(pop);
    cnt_nxt = cnt_r + CW'(push) - CW'(pop);
  end

  // ---------------------------------------------------------------------
  // Entries shift toward the head on pop
  // ---------------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_comb begin
      q_nxt[i] = q_r[i];
      if (pop) begin
        q_nxt[i] = (i < DEPTH - 1) ? q_r[(i < DEPTH - 1) ? i + 1 : i] : q_r[i];
      end
      if (push && (wr_idx == CW'(i))) begin
        q_nxt[i] = in_data_i;
      end
    end

    always_ff @(posedge clk_i) begin
      q_r[i] <= q_nxt[i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r       <= '0;
      out_valid_o <= 1'b0;
      in_ready_o  <= 1'b1;
      room2_o     <= 1'b1;
    end else begin
      cnt_r       <= cnt_nxt;
      out_valid_o <= (cnt_nxt != '0);
      in_ready_o  <= (cnt_nxt != CW'(DEPTH));
      room2_o     <= (cnt_nxt <= CW'(DEPTH - 2));
    end
  end

  assign out_data_o = q_r[0];

endmodule

// ===== src/ecr_frame_mem.sv
// Two-bank control-input frame store: one write port, one registered read.
// Assumes one clock; contents are undefined until first written.
module ecr_frame_mem #(
  parameter int AW = 6,
  parameter int DW = 8
) (
  input  wire logic          clk_i,
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [DW-1:0] wr_data_i,
  input  wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0]      rd_data_o
);

  logic [DW-1:0] mem_r [2**AW];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_r[rd_addr_i];
  end

endmodule

// ===== src/ecr_redirect.sv
// E1 timeslot redirect between line, data streams and control streams.
// Assumes the framer presents one channel per accepted strobe, channel 0 first
// in each frame, all on clk_i; registers reached over classic Wishbone.
module ecr_redirect
  import ecr_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [3:0]        adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic [31:0]            dat_o,
  output logic                   ack_o,
  // Per-channel input from the framer
  input  wire logic              ch_valid_i,
  output logic                   ch_ready_o,
  input  wire logic [CH_W-1:0]   ch_num_i,
  input  wire logic [BYTE_W-1:0] line_rx_i,
  input  wire logic [BYTE_W-1:0] data_stream_in_i,
  input  wire logic [BYTE_W-1:0] control_stream_in_i,
  // Per-channel output
  output logic                   out_valid_o,
  input  wire logic              out_ready_i,
  output logic [CH_W-1:0]        out_ch_o,
  output logic [BYTE_W-1:0]      line_tx_o,
  output logic [BYTE_W-1:0]      data_stream_out_o,
  output logic [BYTE_W-1:0]      control_stream_out_o
);

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  logic                slot31_redirect_en_r, slot31_redirect_en_nxt;
  logic                slot16_redirect_en_r, slot16_redirect_en_nxt;
  logic                slot15_redirect_en_r, slot15_redirect_en_nxt;
  logic [CH_W-1:0]     map31_r, map31_nxt;
  logic [CH_W-1:0]     map16_r, map16_nxt;
  logic [CH_W-1:0]     map15_r, map15_nxt;
  logic                common_channel_sig_select_r, common_channel_sig_select_nxt;
  logic                ack_r, ack_nxt;
  logic [31:0]         rdat_r, rdat_nxt;
  logic                wr_stb;

  ecr_state_type       state_r, state_nxt;
  logic                bank_r, bank_nxt;
  logic [CH_W-1:0]     last_ch_r, last_ch_nxt;
  logic [BYTE_W-1:0]   cap31_r, cap31_nxt, hold31_r, hold31_nxt;
  logic [BYTE_W-1:0]   cap16_r, cap16_nxt, hold16_r, hold16_nxt;
  logic [BYTE_W-1:0]   cap15_r, cap15_nxt, hold15_r, hold15_nxt;
  logic                s1_valid_r, s1_valid_nxt;
  logic [CH_W-1:0]     s1_ch_r, s1_ch_nxt;
  logic [BYTE_W-1:0]   s1_data_stream_in_r, s1_data_stream_in_nxt;
  logic [BYTE_W-1:0]   s1_rx_r, s1_rx_nxt;
  logic [BYTE_W-1:0]   s1_control_stream_out_r, s1_control_stream_out_nxt;
  logic                s1_redir_r, s1_redir_nxt;

  logic                accept;
  logic                frame_start;
  logic                wr_bank;
  logic                act31, act16, act15;
  logic [CH_W-1:0]     rd_ch;
  logic [BYTE_W-1:0]   mem_rdata;
  logic [BYTE_W-1:0]   tx_byte;
  logic                fifo_room2;
  logic [FIFO_W-1:0]   fifo_in;
  logic [FIFO_W-1:0]   fifo_out;

  // ---------------------------------------------------------------------
  // Wishbone register file
  // ---------------------------------------------------------------------
  always_comb begin
    wr_stb                        = cyc_i & stb_i & we_i & ~ack_r;
    ack_nxt                       = cyc_i & stb_i & ~ack_r;
    slot31_redirect_en_nxt        = slot31_redirect_en_r;
    slot16_redirect_en_nxt        = slot16_redirect_en_r;
    slot15_redirect_en_nxt        = slot15_redirect_en_r;
    map31_nxt                     = map31_r;
    map16_nxt                     = map16_r;
    map15_nxt                     = map15_r;
    common_channel_sig_select_nxt = common_channel_sig_select_r;
    rdat_nxt                      = '0;
    if (wr_stb) begin
      case (adr_i)
        OFS_REDIRECT_CTRL: begin
          if (sel_i[0]) begin
            slot31_redirect_en_nxt = dat_i[CTRL_EN31_BIT];
            slot16_redirect_en_nxt = dat_i[CTRL_EN16_BIT];
            slot15_redirect_en_nxt = dat_i[CTRL_EN15_BIT];
          end
        end
        OFS_CHANNEL_MAP: begin
          if (sel_i[0]) begin
            map15_nxt       = dat_i[MAP15_LSB +: CH_W];
            map16_nxt[2:0]  = dat_i[MAP16_LSB +: 3];
          end
          if (sel_i[1]) begin
            map16_nxt[4:3]  = dat_i[MAP16_LSB + 3 +: 2];
            map31_nxt       = dat_i[MAP31_LSB +: CH_W];
          end
        end
        OFS_SIG_CFG: begin
          if (sel_i[0]) begin
            common_channel_sig_select_nxt = dat_i[SIGCFG_CCS_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    if (ack_nxt && !we_i) begin
      case (adr_i)
        OFS_REDIRECT_CTRL: begin
          rdat_nxt[CTRL_EN31_BIT] = slot31_redirect_en_r;
          rdat_nxt[CTRL_EN16_BIT] = slot16_redirect_en_r;
          rdat_nxt[CTRL_EN15_BIT] = slot15_redirect_en_r;
        end
        OFS_CHANNEL_MAP: begin
          rdat_nxt[MAP31_LSB +: CH_W] = map31_r;
          rdat_nxt[MAP16_LSB +: CH_W] = map16_r;
          rdat_nxt[MAP15_LSB +: CH_W] = map15_r;
        end
        OFS_SIG_CFG: begin
          rdat_nxt[SIGCFG_CCS_BIT] = common_channel_sig_select_r;
        end
        OFS_STATUS: begin
          rdat_nxt[STAT_CH_LSB +: CH_W] = last_ch_r;
          rdat_nxt[STAT_BANK_BIT]       = bank_r;
          rdat_nxt[STAT_SYNC_BIT]       = (state_r == ECR_FRAME);
          rdat_nxt[STAT_OUTV_BIT]       = out_valid_o;
        end
        default: begin
          rdat_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot31_redirect_en_r        <= CTRL_RESET[CTRL_EN31_BIT];
      slot16_redirect_en_r        <= CTRL_RESET[CTRL_EN16_BIT];
      slot15_redirect_en_r        <= CTRL_RESET[CTRL_EN15_BIT];
      map31_r                     <= MAP31_RESET;
      map16_r                     <= MAP16_RESET;
      map15_r                     <= MAP15_RESET;
      common_channel_sig_select_r <= CCS_RESET;
      ack_r                       <= 1'b0;
      rdat_r                      <= '0;
    end else begin
      slot31_redirect_en_r        <= slot31_redirect_en_nxt;
      slot16_redirect_en_r        <= slot16_redirect_en_nxt;
      slot15_redirect_en_r        <= slot15_redirect_en_nxt;
      map31_r                     <= map31_nxt;
      map16_r                     <= map16_nxt;
      map15_r                     <= map15_nxt;
      common_channel_sig_select_r <= common_channel_sig_select_nxt;
      ack_r                       <= ack_nxt;
      rdat_r                      <= rdat_nxt;
    end
  end

  assign ack_o = ack_r;
  assign dat_o = rdat_r;

  // ---------------------------------------------------------------------
  // Effective redirects and frame tracking
  // ---------------------------------------------------------------------
  always_comb begin
    accept      = ch_valid_i & ch_ready_o;
    frame_start = accept & (ch_num_i == SLOT0);
    act31 = slot31_redirect_en_r & common_channel_sig_select_r & (state_r == ECR_FRAME);
    act16 = slot16_redirect_en_r & common_channel_sig_select_r & (state_r == ECR_FRAME);
    act15 = slot15_redirect_en_r & common_channel_sig_select_r & (state_r == ECR_FRAME);
    wr_bank     = frame_start ? ~bank_r : bank_r;
    state_nxt   = state_r;
    bank_nxt    = wr_bank;
    last_ch_nxt = accept ? ch_num_i : last_ch_r;
    case (state_r)
      ECR_SYNC: begin
        if (frame_start) begin
          state_nxt = ECR_FRAME;
        end
      end
      ECR_FRAME: begin
        state_nxt = ECR_FRAME;
      end
      default: begin
        state_nxt = ECR_SYNC;
      end
    endcase
  end

  // Received redirect slots are captured this frame and replayed next frame
  always_comb begin
    cap31_nxt  = cap31_r;
    cap16_nxt  = cap16_r;
    cap15_nxt  = cap15_r;
    hold31_nxt = hold31_r;
    hold16_nxt = hold16_r;
    hold15_nxt = hold15_r;
    if (frame_start) begin
      hold31_nxt = cap31_r;
      hold16_nxt = cap16_r;
      hold15_nxt = cap15_r;
    end
    if (accept) begin
      case (ch_num_i)
        SLOT31:  cap31_nxt = line_rx_i;
        SLOT16:  cap16_nxt = line_rx_i;
        SLOT15:  cap15_nxt = line_rx_i;
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Stage 0: choose sources, read the previous frame's control input
  // ---------------------------------------------------------------------
  always_comb begin
    rd_ch        = ch_num_i;
    s1_redir_nxt = 1'b0;
    case (ch_num_i)
      SLOT31: begin
        rd_ch        = map31_r;
        s1_redir_nxt = act31;
      end
      SLOT16: begin
        rd_ch        = map16_r;
        s1_redir_nxt = act16;
      end
      SLOT15: begin
        rd_ch        = map15_r;
        s1_redir_nxt = act15;
      end
      default: begin
        s1_redir_nxt = 1'b0;
      end
    endcase
    // Next-value hold so channel 0 already sees the frame just ended
    s1_control_stream_out_nxt = IDLE_BYTE;
    if (act15 && (map15_r == ch_num_i)) begin
      s1_control_stream_out_nxt = hold15_nxt;
    end
    if (act16 && (map16_r == ch_num_i)) begin
      s1_control_stream_out_nxt = hold16_nxt;
    end
    if (act31 && (map31_r == ch_num_i)) begin
      s1_control_stream_out_nxt = hold31_nxt;
    end
    s1_valid_nxt = accept;
    s1_ch_nxt    = accept ? ch_num_i : s1_ch_r;
    s1_data_stream_in_nxt  = accept ? data_stream_in_i : s1_data_stream_in_r;
    s1_rx_nxt    = accept ? line_rx_i : s1_rx_r;
    if (!accept) begin
      s1_redir_nxt = s1_redir_r;
      s1_control_stream_out_nxt  = s1_control_stream_out_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= ECR_SYNC;
      bank_r     <= 1'b0;
      last_ch_r  <= '0;
      cap31_r    <= IDLE_BYTE;
      cap16_r    <= IDLE_BYTE;
      cap15_r    <= IDLE_BYTE;
      hold31_r   <= IDLE_BYTE;
      hold16_r   <= IDLE_BYTE;
      hold15_r   <= IDLE_BYTE;
      s1_valid_r <= 1'b0;
      s1_ch_r    <= '0;
      s1_data_stream_in_r  <= '0;
      s1_rx_r    <= '0;
      s1_control_stream_out_r  <= IDLE_BYTE;
      s1_redir_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      bank_r     <= bank_nxt;
      last_ch_r  <= last_ch_nxt;
      cap31_r    <= cap31_nxt;
      cap16_r    <= cap16_nxt;
      cap15_r    <= cap15_nxt;
      hold31_r   <= hold31_nxt;
      hold16_r   <= hold16_nxt;
      hold15_r   <= hold15_nxt;
      s1_valid_r <= s1_valid_nxt;
      s1_ch_r    <= s1_ch_nxt;
      s1_data_stream_in_r  <= s1_data_stream_in_nxt;
      s1_rx_r    <= s1_rx_nxt;
      s1_control_stream_out_r  <= s1_control_stream_out_nxt;
      s1_redir_r <= s1_redir_nxt;
    end
  end

  ecr_frame_mem #(
    .AW (MEM_AW),
    .DW (BYTE_W)
  ) u_cst_store (
    .clk_i     (clk_i),
    .wr_en_i   (accept),
    .wr_addr_i ({wr_bank, ch_num_i}),
    .wr_data_i (control_stream_in_i),
    .rd_addr_i ({~wr_bank, rd_ch}),
    .rd_data_o (mem_rdata)
  );

  // ---------------------------------------------------------------------
  // Stage 1: assemble the channel and queue it
  // ---------------------------------------------------------------------
  always_comb begin
    tx_byte = s1_redir_r ? mem_rdata : s1_data_stream_in_r;
    // Data-out always carries the received slot, redirected or not
    fifo_in = {s1_ch_r, tx_byte, s1_rx_r, s1_control_stream_out_r};
  end

  ecr_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_out_fifo (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (s1_valid_r),
    .in_ready_o  (),
    .room2_o     (fifo_room2),
    .in_data_i   (fifo_in),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i),
    .out_data_o  (fifo_out)
  );

  // Two free entries guarantee room for the channel already in stage 1
  assign ch_ready_o           = fifo_room2;
  assign out_ch_o             = fifo_out[FIFO_W-1 -: CH_W];
  assign line_tx_o            = fifo_out[3*BYTE_W-1 -: BYTE_W];
  assign data_stream_out_o    = fifo_out[2*BYTE_W-1 -: BYTE_W];
  assign control_stream_out_o = fifo_out[BYTE_W-1:0];

endmodule

// ===== bench/ecr_redirect_props.sv
// Concurrent checks on the redirect block's ports, bound into every instance.
// Assumes Wishbone writes land on the taking edge and one register read per ack.
module ecr_redirect_props
  import ecr_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic              we_i,
  input wire logic [3:0]        adr_i,
  input wire logic [3:0]        sel_i,
  input wire logic [31:0]       dat_i,
  input wire logic [31:0]       dat_o,
  input wire logic              ack_o,
  input wire logic              ch_valid_i,
  input wire logic              ch_ready_o,
  input wire logic [CH_W-1:0]   ch_num_i,
  input wire logic [BYTE_W-1:0] line_rx_i,
  input wire logic [BYTE_W-1:0] data_stream_in_i,
  input wire logic [BYTE_W-1:0] control_stream_in_i,
  input wire logic              out_valid_o,
  input wire logic              out_ready_i,
  input wire logic [CH_W-1:0]   out_ch_o,
  input wire logic [BYTE_W-1:0] line_tx_o,
  input wire logic [BYTE_W-1:0] data_stream_out_o,
  input wire logic [BYTE_W-1:0] control_stream_out_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------
  // Shadow of the writable registers
  // ------------------------------------
  logic [2:0]  ctrl_r;
  logic [15:0] map_r;
  logic        ccs_r;
  logic        eff_r;
  logic        map_wr_r;
  logic        take;
  logic        wr;
  assign take = cyc_i && stb_i && !ack_o;
  assign wr = take && we_i && sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RESET;
      map_r <= {1'b0, MAP31_RESET, MAP16_RESET, MAP15_RESET};
      ccs_r <= CCS_RESET;
      eff_r <= 1'b0;
      map_wr_r <= 1'b0;
    end else begin
      eff_r <= eff_r || (ccs_r && ctrl_r != 3'h0);
      if (wr && adr_i == OFS_REDIRECT_CTRL) ctrl_r <= dat_i[2:0];
      if (wr && adr_i == OFS_SIG_CFG) ccs_r <= dat_i[0];
      if (take && we_i && adr_i == OFS_CHANNEL_MAP) begin
        map_wr_r <= 1'b1;
        if (sel_i[0]) map_r[7:0] <= dat_i[7:0];
        if (sel_i[1]) map_r[14:8] <= dat_i[14:8];
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ACK_ONE: assert property (take |=> ack_o)
    else $error("No ack in the cycle after a request");
  AST_ACK_DROP: assert property (ack_o |=> !ack_o)
    else $error("Ack held longer than one cycle");
  AST_CTRL_READ: assert property (ack_o && !we_i && adr_i == OFS_REDIRECT_CTRL |->
    dat_o == {29'h0, ctrl_r}) else $error("Control read differs from written value");
  AST_MAP_READ: assert property (ack_o && !we_i && adr_i == OFS_CHANNEL_MAP |->
    dat_o == {16'h0, map_r}) else $error("Map read differs from written value");
  AST_MAP31_RESET: assert property (ack_o && !we_i && adr_i == OFS_CHANNEL_MAP
    && !map_wr_r |-> dat_o[15:10] == 6'h1f) else $error("Slot 31 map not all ones");
  AST_CSO_IDLE: assert property (out_valid_o && !eff_r |->
    control_stream_out_o == IDLE_BYTE) else $error("Control out used while off");
  AST_OUT_HOLD: assert property (out_valid_o && !out_ready_i |=> out_valid_o
    && $stable(out_ch_o) && $stable(line_tx_o) && $stable(data_stream_out_o)
    && $stable(control_stream_out_o)) else $error("Output head changed while stalled");
  AST_OUT_LAT: assert property (ch_valid_i && ch_ready_o && !out_valid_o |->
    ##[1:2] out_valid_o) else $error("Accepted channel did not reach the output");

  COV_WRITE: cover property (take && we_i);
  COV_STALL: cover property (out_valid_o && !out_ready_i);
  COV_REDIR: cover property (out_valid_o && control_stream_out_o != IDLE_BYTE);
endmodule

bind ecr_redirect ecr_redirect_props i_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .sel_i, .dat_i, .dat_o, .ack_o, .ch_valid_i, .ch_ready_o, .ch_num_i, .line_rx_i,
  .data_stream_in_i, .control_stream_in_i, .out_valid_o, .out_ready_i, .out_ch_o,
  .line_tx_o, .data_stream_out_o, .control_stream_out_o);

// ===== bench/ecr_far_end.sv
// Framer and stream side model: offers three frames of channels 0..31 in order.
// Assumes bytes encode their position; consumer stalls 7 of 8 cycles when asked.
module ecr_far_end
  import ecr_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         run_i,
  input  wire logic         stall_i,
  input  wire logic         ch_ready_i,
  output logic              ch_valid_o,
  output logic [CH_W-1:0]   ch_num_o,
  output logic [BYTE_W-1:0] line_rx_o,
  output logic [BYTE_W-1:0] data_in_o,
  output logic [BYTE_W-1:0] ctrl_in_o,
  output logic              out_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] pos_r;
  logic [7:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      pos_r <= 7'h00;
    end else if (ch_valid_o && ch_ready_i) begin
      pos_r <= pos_r + 7'h01;
    end
    if (rst_i) begin
      cnt_r <= 8'h00;
      out_ready_o <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      out_ready_o <= !stall_i || (cnt_r[2:0] == 3'h0);
    end
  end

  // Idle lines show a changing pattern, not the last channel
  always_comb begin
    ch_valid_o = run_i && (pos_r < 7'h60);
    ch_num_o = ch_valid_o ? pos_r[4:0] : cnt_r[4:0];
    line_rx_o = ch_valid_o ? {1'b0, pos_r} : cnt_r;
    data_in_o = ch_valid_o ? {1'b1, ~pos_r} : ~cnt_r;
    ctrl_in_o = ch_valid_o ? ({1'b1, pos_r} ^ 8'h33) : cnt_r;
  end
endmodule

// ===== bench/test_ecr_redirect.sv
// Self-checking bench for the timeslot redirect block.
// Assumes the far-end model's byte coding: rx={0,pos}, data={1,~pos}, ctrl={1,pos}^33.
module test_ecr_redirect
  import ecr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0]  en;
    logic [15:0] map;
    logic        ccs;
    logic        stall;
  } ecr_row_type;
  localparam ecr_row_type ROWS [6] = '{
    '{3'h7, 16'h7e0f, 1'b1, 1'b0}, '{3'h7, 16'h081f, 1'b1, 1'b1},
    '{3'h7, 16'h7e0f, 1'b0, 1'b0}, '{3'h0, 16'h7e0f, 1'b1, 1'b1},
    '{3'h5, 16'h0c63, 1'b1, 1'b0}, '{3'h2, 16'h7fe0, 1'b1, 1'b1}};
  localparam logic [CH_W-1:0] SLOTS [3] = '{SLOT15, SLOT16, SLOT31};

  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, run, saw_refuse;
  logic ch_valid_i, ch_ready_o, out_valid_o, out_ready_i;
  logic [3:0] adr_i, sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic [CH_W-1:0] ch_num_i, out_ch_o, m;
  logic [7:0] line_rx_i, data_stream_in_i, control_stream_in_i, line_tx_o;
  logic [7:0] data_stream_out_o, control_stream_out_o, e_tx, e_cs, n_out;
  logic [6:0] p;
  ecr_row_type cur;
  int miscompares, n_compared;

  ecr_redirect i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .ch_valid_i, .ch_ready_o, .ch_num_i, .line_rx_i, .data_stream_in_i,
    .control_stream_in_i, .out_valid_o, .out_ready_i, .out_ch_o, .line_tx_o,
    .data_stream_out_o, .control_stream_out_o);
  ecr_far_end i_far (.clk_i, .rst_i, .run_i(run), .stall_i(cur.stall),
    .ch_ready_i(ch_ready_o), .ch_valid_o(ch_valid_i), .ch_num_o(ch_num_i),
    .line_rx_o(line_rx_i), .data_in_o(data_stream_in_i),
    .ctrl_in_o(control_stream_in_i), .out_ready_o(out_ready_i));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, e, s);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ------------------------------------
  // Output monitor with expected bytes
  // ------------------------------------
  always @(posedge clk_i) begin
    if (ch_valid_i === 1'b1 && ch_ready_o === 1'b0) saw_refuse <= 1'b1;
    if (rst_i) begin
      n_out <= 8'h00;
    end else if (out_valid_o === 1'b1 && out_ready_i === 1'b1) begin
      p = n_out[6:0];
      e_tx = {1'b1, ~p};
      e_cs = IDLE_BYTE;
      for (int k = 0; k < 3; k++) begin
        m = cur.map[k*CH_W +: CH_W];
        if (cur.en[k] && cur.ccs && out_ch_o == SLOTS[k]) e_tx = {1'b1, p[6:5] - 2'h1, m} ^ 8'h33;
        if (cur.en[k] && cur.ccs && out_ch_o == m) e_cs = {1'b0, p[6:5] - 2'h1, SLOTS[k]};
      end
      chk("out_ch", {3'h0, p[4:0]}, {3'h0, out_ch_o});
      chk("data_out", {1'b0, p}, data_stream_out_o);
      if (p[6:5] != 2'h0) begin
        chk("line_tx", e_tx, line_tx_o);
        chk("ctrl_out", e_cs, control_stream_out_o);
      end
      n_out <= n_out + 8'h01;
    end
  end

  initial begin
    {cyc_i, stb_i, we_i, run, saw_refuse} = 5'h00;
    {adr_i, sel_i, dat_i} = '0;
    rst_i = 1'b1;
    cur = ROWS[0];
    miscompares = 0;
    n_compared = 0;
    for (int r = 0; r < 6; r++) begin
      cur = ROWS[r];
      do_reset();
      wb(1'b1, OFS_SIG_CFG, {31'h0, cur.ccs});
      wb(1'b1, OFS_CHANNEL_MAP, {16'h0, cur.map});
      wb(1'b1, OFS_REDIRECT_CTRL, {29'h0, cur.en});
      run <= 1'b1;
      wait (n_out == 8'h60);
      wb(1'b0, OFS_STATUS, 32'h0);
      chk("status_run", 8'h7f, q[7:0]);
      @(posedge clk_i);
      run <= 1'b0;
    end
    do_reset();
    wb(1'b0, OFS_REDIRECT_CTRL, 32'h0);
    chk("ctrl_reset", 8'h00, q[7:0]);
    wb(1'b0, OFS_CHANNEL_MAP, 32'h0);
    chk("map_reset", 8'h7e, q[15:8]);
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", 8'h00, q[7:0]);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk("status_reset", 8'h00, q[7:0]);
    wb(1'b1, OFS_CHANNEL_MAP, 32'hffffffff);
    wb(1'b0, OFS_CHANNEL_MAP, 32'h0);
    chk("map_bit15", 8'h7f, q[15:8]);
    wb(1'b1, OFS_REDIRECT_CTRL, 32'h000000ff);
    wb(1'b0, OFS_REDIRECT_CTRL, 32'h0);
    chk("ctrl_bits", 8'h07, q[7:0]);
    chk("fifo_refused", 8'h01, {7'h0, saw_refuse});
    tally_and_finish();
  end

  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end
endmodule
